// ### serial_port_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

`define SP_MODE_OFS    12'h8b0
`define SP_DESC_OFS    12'h74e

`define SP_GO_BIT      15
`define SP_LOOP_BIT    14
`define SP_INV_BIT     13
`define SP_PM_MSB      12
`define SP_PM_LSB      9
`define SP_EN_BIT      8
`define SP_PHASE_BIT   7
`define SP_LOW_MSB     6
`define SP_DONE_BIT    15
`define SP_DATA_MSB    7

`define SP_PM_RST      4'ha
`define SP_EN_RST      1'b1
`define SP_LOOP_RST    1'b0
`define SP_INV_RST     1'b0
`define SP_PHASE_RST   1'b0
`define SP_LOW_RST     7'h00

`define SP_HALF_LAST   4'hf
`define SP_GAP_FAST    4'h8
`define SP_GAP_MID     4'h4
`define SP_GAP_SLOW    4'h2
`define SP_PM_FAST_MAX 4'h3
`define SP_PM_MID_MAX  4'h7
`define SP_STRAP_WAIT  2'h3

`define SP_OP_ADDR16   8'h03
`define SP_OP_READ     3'b011
`define SP_OP_MIXED    3'b110
`define SP_FMT_ADDR8   2'h1
`define SP_FMT_MIXED   2'h2

`endif

// ### serial_port_pkg.sv
// Types used by the serial port master for its byte engine, sequencer and EEPROM formats.
package serial_port_pkg;
    typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_GAP} eng_state_type;
    typedef enum logic [1:0] {SEQ_STRAP, SEQ_CMD, SEQ_DATA, SEQ_IDLE} seq_state_type;
    typedef enum logic [1:0] {FMT_ADDR16, FMT_ADDR8, FMT_MIXED} eeprom_fmt_type;
endpackage

// ### prescale_divider.sv
// Prescale divider producing one tick per half period of the serial clock.
module prescale_divider #(
    parameter int MOD_W = 4
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // Control
    input  wire logic             run_i,
    input  wire logic [MOD_W-1:0] modulus_i,
    // Tick
    output logic                  half_tick_o
);
    logic [MOD_W:0] cnt;
    wire  [MOD_W:0] limit = {modulus_i, 1'b1};

    // Half period is 2*(modulus+1) clocks, so a full bit is 4*(modulus+1).
    assign half_tick_o = run_i && (cnt == limit);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= '0;
        end else if (!run_i || half_tick_o) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    tick_spacing_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        half_tick_o |=> !half_tick_o) else $error("half ticks closer than two clocks");
endmodule

// ### two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Draining side
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] slot1;
    logic [1:0]       count;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count != 2'd2);
    assign out_valid_o = (count != 2'd0);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_data_o <= '0;
            slot1      <= '0;
            count      <= 2'd0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    if (count == 2'd0) out_data_o <= in_data_i;
                    else slot1 <= in_data_i;
                    count <= count + 2'd1;
                end
                2'b01: begin
                    out_data_o <= slot1;
                    count      <= count - 2'd1;
                end
                2'b11: begin
                    if (count == 2'd1) begin
                        out_data_o <= in_data_i;
                    end else begin
                        out_data_o <= slot1;
                        slot1      <= in_data_i;
                    end
                end
                2'b00: ;
            endcase
        end
    end
endmodule

// ### serial_port_master_eeprom_boot.sv
// Serial port master with mode register, transfer descriptor and EEPROM boot reader.
`include "serial_port_map.svh"

// Overview of operation
// - Port is master, drives clock and selects.
// - Serial clock toggles only during a byte.
// - Gap of two to eight bits between bytes.
// - Bytes shift out most significant bit first.
// - Mode resets enabled with divide by 44.
// - Go bit starts exchange, clears after one clock.
// - Loopback feeds inverted transmit into receiver.
// - Polarity bit inverts clock idle and edges.
// - Divide ratio is four times prescale plus one.
// - Enable connects pins; clear holds port reset.
// - Phase bit selects clock start at beginning.
// - Phase and polarity reset to zero.
// - Descriptor holds done flag and data byte.
// - End writes byte, clears done, raises request.
// - After reset select EEPROM and load boot data.
// - Detect EEPROM addressing format, use its protocol.
// - Resource reads swap slave selects at byte boundaries.
// - Sixteen-bit format: opcode byte, address, then data.
// - Eight-bit format: high address, opcode, low address.
// - Mixed format: opcode 110, address, then data.
module serial_port_master_eeprom_boot
    import serial_port_pkg::*;
#(
    parameter int          BOOT_BYTES = 64,
    parameter int          SEL_W      = 4,
    parameter logic [15:0] BOOT_ADDR  = 16'h0000
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    // Register access
    input  wire logic [11:0]       reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic [15:0]       reg_wdata_i,
    output logic      [15:0]       reg_rdata_o,
    // Transfer completion request
    output logic                   xfer_irq_o,
    // Serial pins
    output logic                   serial_port_clock_o,
    output logic                   serial_transmit_line_o,
    output logic                   serial_pins_oe_o,
    input  wire logic              serial_rx_pin_i,
    // EEPROM select and format strap
    output logic                   eeprom_select_n_o,
    input  wire logic [1:0]        eeprom_format_i,
    // Slave select lines
    input  wire logic [SEL_W-1:0]  port_enable_control_i,
    input  wire logic [SEL_W-1:0]  port_data_value_i,
    output logic      [SEL_W-1:0]  slave_select_lines_o,
    // On-demand resource read
    input  wire logic              pnp_req_i,
    input  wire logic [15:0]       pnp_addr_i,
    output logic                   pnp_busy_o,
    // Boot data stream
    output logic      [7:0]        boot_data_o,
    output logic                   boot_valid_o,
    input  wire logic              boot_ready_i,
    output logic                   boot_done_o
);
    localparam int CNT_W = $clog2(BOOT_BYTES + 1);

    // Mode register fields.
    logic                go_pulse;
    logic                loop_mode;
    logic                clock_polarity_flip;
    logic [3:0]          prescale_select;
    logic                port_en;
    logic                clock_phase_select;
    logic [6:0]          low_bits;

    // Descriptor fields.
    logic                desc_done;
    logic [7:0]          desc_data;

    // Synchronisers.
    logic                rx_meta;
    logic                rx_sync;
    logic [1:0]          fmt_meta;
    logic [1:0]          fmt_sync;

    // Byte engine.
    eng_state_type       eng_state;
    logic [3:0]          half_cnt;
    logic [4:0]          gap_cnt;
    logic [7:0]          tx_shreg;
    logic [7:0]          rx_shreg;
    logic                tx_bit;
    logic                sclk_out;
    logic                half_tick;

    // Boot and resource read sequencer.
    seq_state_type       seq_state;
    eeprom_fmt_type      fmt;
    logic [1:0]          strap_cnt;
    logic [1:0]          byte_idx;
    logic [15:0]         seq_addr;
    logic [CNT_W-1:0]    data_left;
    logic                pnp_run;
    logic                sel_override;
    logic                buf_in_ready;

    // Decoding.
    wire mode_hit  = (reg_addr_i == `SP_MODE_OFS);
    wire desc_hit  = (reg_addr_i == `SP_DESC_OFS);
    wire mode_wr   = reg_wr_i && mode_hit;
    wire desc_wr   = reg_wr_i && desc_hit;
    wire eng_idle  = (eng_state == ENG_IDLE);
    wire seq_idle  = (seq_state == SEQ_IDLE);
    wire lead      = !half_cnt[0];
    wire last_half = (half_cnt == `SP_HALF_LAST);
    wire eng_done  = half_tick && (eng_state == ENG_SHIFT) && last_half;
    wire host_done = eng_done && seq_idle;

    wire [15:0] mode_value = {go_pulse, loop_mode, clock_polarity_flip,
                              prescale_select, port_en, clock_phase_select, low_bits};
    wire [15:0] desc_value = {desc_done, 7'h00, desc_data};
    wire [15:0] rd_value   = mode_hit ? mode_value : (desc_hit ? desc_value : 16'h0000);

    // Loopback ignores the pin and sees the complement of the transmitter.
    wire rx_bit     = loop_mode ? ~tx_bit : rx_sync;
    wire sample_now = clock_phase_select ? !lead : lead;
    wire shift_now  = clock_phase_select ? lead : (!lead && !last_half);
    wire [7:0] rx_byte = sample_now ? {rx_shreg[6:0], rx_bit} : rx_shreg;

    // Faster prescale means a longer idle gap between bytes.
    wire [3:0] gap_bits = (prescale_select <= `SP_PM_FAST_MAX) ? `SP_GAP_FAST :
                          (prescale_select <= `SP_PM_MID_MAX) ? `SP_GAP_MID : `SP_GAP_SLOW;
    wire [4:0] gap_load = {gap_bits, 1'b0} - 5'd1;

    wire [1:0] cmd_last = (fmt == FMT_ADDR16) ? 2'd2 : 2'd1;

    // Command bytes of the three read formats, high bit of each byte first.
    function automatic logic [7:0] cmd_byte(eeprom_fmt_type f, logic [1:0] idx, logic [15:0] a);
        logic [7:0] b;
        logic [2:0] mixed_op;
        b = 8'h00;
        mixed_op = `SP_OP_MIXED;
        unique case (f)
            FMT_ADDR16: b = (idx == 2'd0) ? `SP_OP_ADDR16 :
                            (idx == 2'd1) ? a[15:8] : a[7:0];
            FMT_ADDR8:  b = (idx == 2'd0) ? {a[12:8], `SP_OP_READ} : a[7:0];
            FMT_MIXED:  b = (idx == 2'd0) ? {6'h00, mixed_op[2:1]} :
                                            {mixed_op[0], a[6:0]};
        endcase
        return b;
    endfunction

    wire seq_start  = eng_idle && port_en &&
                      ((seq_state == SEQ_CMD) || ((seq_state == SEQ_DATA) && buf_in_ready));
    wire host_start = go_pulse && eng_idle && seq_idle && port_en;
    wire pnp_take   = pnp_req_i && eng_idle && seq_idle && !go_pulse && port_en;
    wire eng_start  = seq_start || host_start;
    wire [7:0] eng_tx = (seq_state == SEQ_CMD) ? cmd_byte(fmt, byte_idx, seq_addr) :
                        (seq_state == SEQ_DATA) ? 8'h00 : desc_data;

    // Mode register; the go bit lives one clock only.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            go_pulse            <= 1'b0;
            loop_mode           <= `SP_LOOP_RST;
            clock_polarity_flip <= `SP_INV_RST;
            prescale_select     <= `SP_PM_RST;
            port_en             <= `SP_EN_RST;
            clock_phase_select  <= `SP_PHASE_RST;
            low_bits            <= `SP_LOW_RST;
        end else begin
            go_pulse <= mode_wr && reg_wdata_i[`SP_GO_BIT];
            if (mode_wr) begin
                loop_mode           <= reg_wdata_i[`SP_LOOP_BIT];
                clock_polarity_flip <= reg_wdata_i[`SP_INV_BIT];
                prescale_select     <= reg_wdata_i[`SP_PM_MSB:`SP_PM_LSB];
                port_en             <= reg_wdata_i[`SP_EN_BIT];
                clock_phase_select  <= reg_wdata_i[`SP_PHASE_BIT];
                low_bits            <= reg_wdata_i[`SP_LOW_MSB:0];
            end
        end
    end

    // Descriptor; a host write in the completion cycle wins over the clear.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            desc_done  <= 1'b0;
            desc_data  <= 8'h00;
            xfer_irq_o <= 1'b0;
        end else begin
            xfer_irq_o <= host_done;
            if (desc_wr) begin
                desc_done <= reg_wdata_i[`SP_DONE_BIT];
                desc_data <= reg_wdata_i[`SP_DATA_MSB:0];
            end else if (host_done) begin
                desc_done <= 1'b0;
                desc_data <= rx_byte;
            end
        end
    end

    // Read data and pin control come from flip-flops.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o          <= 16'h0000;
            serial_pins_oe_o     <= 1'b0;
            slave_select_lines_o <= '0;
        end else begin
            reg_rdata_o          <= rd_value;
            serial_pins_oe_o     <= port_en;
            slave_select_lines_o <= sel_override ? port_data_value_i : port_enable_control_i;
        end
    end

    // The receive pin and the format strap come from outside the clock domain.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_meta  <= 1'b0;
            rx_sync  <= 1'b0;
            fmt_meta <= 2'h0;
            fmt_sync <= 2'h0;
        end else begin
            rx_meta  <= serial_rx_pin_i;
            rx_sync  <= rx_meta;
            fmt_meta <= eeprom_format_i;
            fmt_sync <= fmt_meta;
        end
    end

    prescale_divider #(
        .MOD_W (4)
    ) u_divider (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .run_i       (port_en && !eng_idle),
        .modulus_i   (prescale_select),
        .half_tick_o (half_tick)
    );

    // Byte engine: sixteen half periods, then an idle gap.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eng_state <= ENG_IDLE;
            half_cnt  <= 4'h0;
            gap_cnt   <= 5'h00;
            tx_shreg  <= 8'h00;
            rx_shreg  <= 8'h00;
            tx_bit    <= 1'b0;
            sclk_out  <= 1'b0;
        end else if (!port_en) begin
            eng_state <= ENG_IDLE;
            half_cnt  <= 4'h0;
            tx_bit    <= 1'b0;
            sclk_out  <= clock_polarity_flip;
        end else begin
            unique case (eng_state)
                ENG_IDLE: begin
                    sclk_out <= clock_polarity_flip;
                    if (eng_start) begin
                        eng_state <= ENG_SHIFT;
                        half_cnt  <= 4'h0;
                        if (!clock_phase_select) begin
                            tx_bit   <= eng_tx[7];
                            tx_shreg <= {eng_tx[6:0], 1'b0};
                        end else begin
                            tx_shreg <= eng_tx;
                        end
                    end
                end
                ENG_SHIFT: begin
                    if (half_tick) begin
                        sclk_out <= ~sclk_out;
                        half_cnt <= half_cnt + 4'h1;
                        if (shift_now) begin
                            tx_bit   <= tx_shreg[7];
                            tx_shreg <= {tx_shreg[6:0], 1'b0};
                        end
                        if (sample_now) begin
                            rx_shreg <= {rx_shreg[6:0], rx_bit};
                        end
                        if (last_half) begin
                            eng_state <= ENG_GAP;
                            gap_cnt   <= gap_load;
                        end
                    end
                end
                ENG_GAP: begin
                    sclk_out <= clock_polarity_flip;
                    if (half_tick) begin
                        if (gap_cnt == 5'h00) eng_state <= ENG_IDLE;
                        else gap_cnt <= gap_cnt - 5'h01;
                    end
                end
                default: eng_state <= ENG_IDLE;
            endcase
        end
    end

    assign serial_port_clock_o    = sclk_out;
    assign serial_transmit_line_o = tx_bit;

    // Boot load after reset, then on-demand resource reads.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_state         <= SEQ_STRAP;
            fmt               <= FMT_ADDR16;
            strap_cnt         <= 2'h0;
            byte_idx          <= 2'h0;
            seq_addr          <= 16'h0000;
            data_left         <= '0;
            pnp_run           <= 1'b0;
            sel_override      <= 1'b0;
            eeprom_select_n_o <= 1'b1;
            boot_done_o       <= 1'b0;
        end else begin
            unique case (seq_state)
                SEQ_STRAP: begin
                    if (strap_cnt == `SP_STRAP_WAIT) begin
                        fmt <= (fmt_sync == `SP_FMT_ADDR8) ? FMT_ADDR8 :
                               (fmt_sync == `SP_FMT_MIXED) ? FMT_MIXED : FMT_ADDR16;
                        seq_state         <= SEQ_CMD;
                        byte_idx          <= 2'h0;
                        seq_addr          <= BOOT_ADDR;
                        data_left         <= CNT_W'(BOOT_BYTES - 1);
                        eeprom_select_n_o <= 1'b0;
                    end else begin
                        strap_cnt <= strap_cnt + 2'h1;
                    end
                end
                SEQ_CMD: begin
                    if (eng_done) begin
                        byte_idx <= byte_idx + 2'h1;
                        if (byte_idx == cmd_last) seq_state <= SEQ_DATA;
                    end
                end
                SEQ_DATA: begin
                    // Continuous read: no new address between data bytes.
                    if (eng_done) begin
                        if (data_left == '0) begin
                            seq_state         <= SEQ_IDLE;
                            eeprom_select_n_o <= 1'b1;
                            sel_override      <= 1'b0;
                            pnp_run           <= 1'b0;
                            boot_done_o       <= 1'b1;
                        end else begin
                            data_left <= data_left - 1'b1;
                        end
                    end
                end
                SEQ_IDLE: begin
                    if (pnp_take) begin
                        seq_state         <= SEQ_CMD;
                        byte_idx          <= 2'h0;
                        seq_addr          <= pnp_addr_i;
                        data_left         <= '0;
                        pnp_run           <= 1'b1;
                        sel_override      <= 1'b1;
                        eeprom_select_n_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign pnp_busy_o = pnp_run;

    // The stream stalls the read once the receiver has let both buffer entries fill.
    two_entry_buffer #(
        .WIDTH (8)
    ) u_boot_buffer (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (rx_byte),
        .in_valid_i  (eng_done && (seq_state == SEQ_DATA)),
        .in_ready_o  (buf_in_ready),
        .out_data_o  (boot_data_o),
        .out_valid_o (boot_valid_o),
        .out_ready_i (boot_ready_i)
    );

    go_self_clear_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        go_pulse |=> !go_pulse) else $error("go bit stayed set");

    clock_idle_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (eng_state != ENG_SHIFT) && $past(eng_state != ENG_SHIFT)
        |-> sclk_out == $past(clock_polarity_flip)) else $error("serial clock not idle");

    byte_gap_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(eng_state == ENG_SHIFT) |-> (eng_state != ENG_SHIFT)[*8]) else $error("gap too short");

    msb_first_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        eng_start && !clock_phase_select && port_en |=> tx_bit == $past(eng_tx[7]))
        else $error("first bit not msb");

    loop_sample_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        half_tick && sample_now && loop_mode && port_en && (eng_state == ENG_SHIFT)
        |=> rx_shreg[0] == ~$past(tx_bit)) else $error("loopback bit wrong");

    done_clear_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        host_done && !desc_wr |=> !desc_done && xfer_irq_o) else $error("completion not flagged");

    disable_hold_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !port_en |=> (eng_state == ENG_IDLE) && !serial_pins_oe_o) else $error("port active while off");

    select_hold_a:
    assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (seq_state == SEQ_CMD) || (seq_state == SEQ_DATA) |-> !eeprom_select_n_o)
        else $error("eeprom select dropped mid read");
endmodule

// ### eeprom_partner.sv
// Behavioural serial EEPROM in continuous-read mode.
module eeprom_partner (
    input  wire logic        clk_i,
    input  wire logic        sck_i,
    input  wire logic        sel_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic [23:0]      cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bits = 0;
    logic       bit_q = 0;
    logic       tog = 0;
    logic [7:0] cur;
    // A deselected part floats, so the line shows a changing pattern instead of old data.
    always @(posedge clk_i) tog <= ~tog;
    always @(posedge sck_i or posedge sel_n_i) begin
        if (sel_n_i) bits <= 0;
        else begin
            if (bits < 24) cmd_o <= {cmd_o[22:0], mosi_i};
            bits <= bits + 1;
        end
    end
    // Bytes keep coming without a new address, each one changing on falling edges.
    always @(negedge sck_i) if (!sel_n_i && bits >= 24) begin
        cur = 8'ha5 ^ 8'((bits - 24) / 8);
        bit_q <= cur[7 - (bits - 24) % 8];
    end
    assign miso_o = sel_n_i ? tog : bit_q;
endmodule

// ### serial_port_master_eeprom_boot_bench.sv
// Self-checking bench for the serial port master with EEPROM boot.
module serial_port_master_eeprom_boot_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 0, rstn_i = 0, reg_wr_i = 0, boot_ready_i = 0, pnp_req_i = 0;
    logic        rx, irq, sck, sck_q, txd, oe, e2_n, bvalid, bdone, busy;
    logic [11:0] reg_addr_i = 0;
    logic [15:0] reg_wdata_i = 0, reg_rdata_o, exp_q[$], pnp_addr_i = 0;
    logic [3:0]  sel_i = 0, sel_o, port_data_value_i = 0;
    logic [7:0]  bdata;
    logic [23:0] cmd;
    int          seed = 32'hceb8eb37, num_errors = 0, checks = 0, cyc = 0, edges = 0, first_e, last_e;
    serial_port_master_eeprom_boot #(.BOOT_BYTES(4), .SEL_W(4), .BOOT_ADDR(16'h1234)) u_serial_port_master_eeprom_boot (
        .ref_clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .xfer_irq_o(irq),
        .serial_port_clock_o(sck), .serial_transmit_line_o(txd), .serial_pins_oe_o(oe), .serial_rx_pin_i(rx),
        .eeprom_select_n_o(e2_n), .eeprom_format_i(2'h0), .port_enable_control_i(sel_i),
        .port_data_value_i, .slave_select_lines_o(sel_o), .pnp_req_i, .pnp_addr_i,
        .pnp_busy_o(busy), .boot_data_o(bdata), .boot_valid_o(bvalid), .boot_ready_i, .boot_done_o(bdone));
    eeprom_partner u_eeprom_partner (.clk_i(ref_clk_i), .sck_i(sck), .sel_n_i(e2_n), .mosi_i(txd),
        .miso_o(rx), .cmd_o(cmd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk_i) #1;
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(posedge ref_clk_i) #1;
        reg_wr_i = 0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge ref_clk_i) #1;
        reg_addr_i = a;
        @(posedge ref_clk_i) #1;
        d = reg_rdata_o;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #10 ref_clk_i = ~ref_clk_i;
    // Serial clock edges are logged by cycle so the bit period can be measured.
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        sck_q <= sck;
        if (sck !== sck_q) begin
            edges <= edges + 1;
            if (edges == 0) first_e <= cyc;
            last_e <= cyc;
        end
        if (bvalid === 1'b1 && boot_ready_i) chk({8'h00, bdata}, exp_q.pop_front());
        boot_ready_i <= #1 1'($random(seed));
    end
    initial begin
        #1_500_000;
        num_errors++;
        test_done();
    end
    initial begin
        logic [15:0] d, m, tx;
        int pm;
        for (int k = 0; k < 4; k++) exp_q.push_back({8'h00, 8'ha5 ^ 8'(k)});
        repeat (10) @(posedge ref_clk_i);
        #1 rstn_i = 1;
        rd(12'h8b0, d);
        chk(d, 16'h1500);
        chk({15'h0, oe}, 16'h0001);
        wait (bdone === 1'b1 && exp_q.size() == 0);
        repeat (2) @(posedge ref_clk_i);
        chk({8'h00, cmd[23:16]}, 16'h0003);
        chk(cmd[15:0], 16'h1234);
        chk({15'h0, e2_n}, 16'h0001);
        #1 sel_i = 4'($random(seed));
        repeat (3) @(posedge ref_clk_i);
        chk({12'h0, sel_o}, {12'h0, sel_i});
        rd(12'h123, d);
        chk(d, 16'h0000);
        $display("boot load done");
        exp_q.push_back(16'h00a5);
        port_data_value_i = 4'($random(seed));
        pnp_addr_i = 16'($random(seed));
        @(posedge ref_clk_i) #1 pnp_req_i = 1;
        wait (busy === 1'b1);
        #1 pnp_req_i = 0;
        repeat (3) @(posedge ref_clk_i);
        chk({12'h0, sel_o}, {12'h0, port_data_value_i});
        wait (busy === 1'b0 && exp_q.size() == 0);
        repeat (3) @(posedge ref_clk_i);
        chk({12'h0, sel_o}, {12'h0, sel_i});
        chk(cmd[15:0], pnp_addr_i);
        chk({15'h0, e2_n}, 16'h0001);
        $display("resource read done");
        // The engine refuses a go bit until the previous byte's gap has run out.
        pm = 10;
        for (int i = 0; i < 4; i++) begin
            repeat (4 * (pm + 1) * ((pm <= 3) ? 8 : (pm <= 7) ? 4 : 2)) @(posedge ref_clk_i);
            pm = i * 4 + 3;
            m = {2'b01, i[0], 4'(pm), 1'b1, i[1], 7'h00};
            tx = {8'h80, 8'($random(seed))};
            wr(12'h8b0, m);
            wr(12'h74e, tx);
            wr(12'h8b0, m | 16'h8000);
            edges = 0;
            rd(12'h8b0, d);
            chk(d, m);
            repeat (3000) begin
                @(posedge ref_clk_i) #1;
                if (irq === 1'b1) break;
            end
            chk({15'h0, irq}, 16'h0001);
            rd(12'h74e, d);
            chk(d, {8'h00, ~tx[7:0]});
            chk(16'(edges), 16'd16);
            chk(16'(last_e - first_e), 16'(30 * (pm + 1)));
            chk({15'h0, sck}, {15'h0, i[0]});
            $display("transfer %0d done", i);
        end
        wr(12'h8b0, 16'h0000);
        repeat (2) @(posedge ref_clk_i);
        chk({15'h0, oe}, 16'h0000);
        $display("disable done");
        test_done();
    end
endmodule
